// *** rtl/pcrs_consts.svh ***
// constants for the program counter and return stack block
`ifndef PCRS_CONSTS_SVH
`define PCRS_CONSTS_SVH

`define PCRS_PC_W         21
`define PCRS_PTR_W        5
`define PCRS_DEPTH        31
`define PCRS_ADDR_W       3
`define PCRS_DATA_W       8

// register offsets on the plain register port
`define PCRS_OFS_PC_LOW   3'h0
`define PCRS_OFS_LAT_HIGH 3'h1
`define PCRS_OFS_LAT_UPR  3'h2
`define PCRS_OFS_STK_IDX  3'h3
`define PCRS_OFS_TOS_LOW  3'h4
`define PCRS_OFS_TOS_HIGH 3'h5
`define PCRS_OFS_TOS_UPR  3'h6

// stack index register fields
`define PCRS_IDX_OVF_BIT  7
`define PCRS_IDX_UDF_BIT  6
`define PCRS_IDX_FULL_BIT 5

// reset values and fixed addresses
`define PCRS_PC_RST       21'h000000
`define PCRS_PTR_RST      5'h00
`define PCRS_PTR_MAX      5'h1f
`define PCRS_PC_STEP      21'h000002
`define PCRS_VEC_HIGH     21'h000008
`define PCRS_VEC_LOW      21'h000018
`define PCRS_UPR_MASK     8'h1f

`endif

// *** rtl/pcrs_pkg.sv ***
// types shared by the program counter and return stack block
`include "pcrs_consts.svh"

package pcrs_pkg;

   typedef enum logic [2:0] {
      PCRS_OP_NONE = 3'h0,
      PCRS_OP_SEQ  = 3'h1,
      PCRS_OP_JUMP = 3'h2,
      PCRS_OP_CALL = 3'h3,
      PCRS_OP_RET  = 3'h4,
      PCRS_OP_INT  = 3'h5
   } pcrs_op_kind_t;

   typedef struct packed {
      pcrs_op_kind_t                kind;
      logic [`PCRS_PC_W-1:0]        target;
      logic                         low_prio;
   } pcrs_op_t;

   typedef struct packed {
      logic                         wr;
      logic                         rd;
      logic [`PCRS_ADDR_W-1:0]      addr;
      logic [`PCRS_DATA_W-1:0]      wdata;
   } pcrs_bus_t;

endpackage

// *** rtl/pcrs_stack_mem.sv ***
// return stack storage: entries 1..DEPTH, index 0 has no storage
`timescale 1ns/1ps
`default_nettype none
`include "pcrs_consts.svh"

module pcrs_stack_mem #(
   parameter int DEPTH = `PCRS_DEPTH,
   parameter int WIDTH = `PCRS_PC_W,
   parameter int AW    = `PCRS_PTR_W
) (
   // clock and reset
   input  wire logic             i_clk,
   input  wire logic             i_rst_b,
   // write port, byte lanes
   input  wire logic             i_wr_en,
   input  wire logic [AW-1:0]    i_wr_idx,
   input  wire logic [2:0]       i_wr_lane,
   input  wire logic [WIDTH-1:0] i_wr_data,
   // read port
   input  wire logic [AW-1:0]    i_rd_idx,
   output logic      [WIDTH-1:0] o_rd_data
);

   logic [WIDTH-1:0] mem_q [1:DEPTH];
   logic [WIDTH-1:0] mem_d [1:DEPTH];

   always_comb begin
      for (int e = 1; e <= DEPTH; e++) begin
         mem_d[e] = mem_q[e];
         for (int b = 0; b < WIDTH; b++) begin
            if (i_wr_en && (int'(i_wr_idx) == e) && i_wr_lane[b / 8]) begin
               mem_d[e][b] = i_wr_data[b];
            end
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         for (int e = 1; e <= DEPTH; e++) begin
            mem_q[e] <= '0;
         end
      end else begin
         for (int e = 1; e <= DEPTH; e++) begin
            mem_q[e] <= mem_d[e];
         end
      end
   end

   // index 0 and out-of-range indices read as zero
   always_comb begin
      o_rd_data = '0;
      if ((i_rd_idx != '0) && (int'(i_rd_idx) <= DEPTH)) begin
         o_rd_data = mem_q[i_rd_idx];
      end
   end

endmodule

`default_nettype wire

// *** rtl/pcrs_top.sv ***
// program counter, address latches and hardware return stack
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pcrs_consts.svh"

// Summary of operation
// - program counter is 21 bits, held as low, high and upper bytes
// - low byte readable and writable; high byte not directly readable or writable, software loads it via high latch
// - upper byte bits 20..16 reached only through the upper latch
// - writing the low byte loads high and upper bytes from the latches
// - reading the low byte copies high and upper bytes into the latches
// - bit 0 always zero; sequential step adds two
// - call, relative call, goto, branch load target directly, latches unused
// - stack holds 31 nested calls/interrupts; push on call/ack, pop on returns
// - call and return leave both latches unchanged
// - stack is private 31 by 21 storage indexed by 5-bit pointer
// - push increments pointer first, then writes counter into that entry
// - pop loads counter from current entry, then decrements pointer
// - reset clears pointer; index zero has no storage
// - flags report stack full, overflow and underflow
// - pointer readable/writable; top entry visible and writable as three bytes
// - software can push and pop through pointer and top registers
// - interrupt with an enable set pushes counter, then loads 0008h or 0018h
module pcrs_top (
   // clock and reset
   input  wire logic                    i_clk,
   input  wire logic                    i_rst_b,
   // core operation from decode and interrupt logic
   input  wire pcrs_pkg::pcrs_op_t      i_op,
   input  wire logic                    i_global_int_enable_high,
   input  wire logic                    i_global_int_enable_low,
   // register port
   input  wire pcrs_pkg::pcrs_bus_t     i_bus,
   output logic [`PCRS_DATA_W-1:0]      o_rd_data,
   // counter and stack status
   output logic [`PCRS_PC_W-1:0]        o_program_counter,
   output logic [`PCRS_PTR_W-1:0]       o_stack_index,
   output logic                         o_stack_full,
   output logic                         o_stack_overflow,
   output logic                         o_stack_underflow
);

   logic [`PCRS_PC_W-1:0]   pc_q;
   logic [`PCRS_PC_W-1:0]   pc_d;
   logic [7:0]              lat_high_q;
   logic [7:0]              lat_high_d;
   logic [7:0]              lat_upr_q;
   logic [7:0]              lat_upr_d;
   logic [`PCRS_PTR_W-1:0]  ptr_q;
   logic [`PCRS_PTR_W-1:0]  ptr_d;
   logic                    ovf_q;
   logic                    ovf_d;
   logic                    udf_q;
   logic                    udf_d;
   logic                    full_q;
   logic                    full_d;
   logic [`PCRS_DATA_W-1:0] rd_q;
   logic [`PCRS_DATA_W-1:0] rd_d;

   logic                    mem_we;
   logic [`PCRS_PTR_W-1:0]  mem_widx;
   logic [2:0]              mem_lane;
   logic [`PCRS_PC_W-1:0]   mem_wdata;
   logic [`PCRS_PTR_W-1:0]  mem_ridx;
   logic [`PCRS_PC_W-1:0]   top_of_stack_entry;

   logic                    core_busy;
   logic                    do_push;
   logic                    do_pop;
   logic                    int_taken;
   logic                    bus_wr_low;
   logic                    bus_rd_low;
   logic                    idx_wr;

   // interrupt push only when the interrupt logic has an enable set
   assign int_taken  = (i_op.kind == pcrs_pkg::PCRS_OP_INT)
                       && (i_global_int_enable_high || i_global_int_enable_low);
   assign do_push    = (i_op.kind == pcrs_pkg::PCRS_OP_CALL) || int_taken;
   assign do_pop     = (i_op.kind == pcrs_pkg::PCRS_OP_RET);
   // the core owns counter and pointer in a cycle where it issues an operation
   assign core_busy  = (i_op.kind != pcrs_pkg::PCRS_OP_NONE);
   assign bus_wr_low = i_bus.wr && (i_bus.addr == `PCRS_OFS_PC_LOW);
   assign bus_rd_low = i_bus.rd && (i_bus.addr == `PCRS_OFS_PC_LOW);
   assign idx_wr     = i_bus.wr && (i_bus.addr == `PCRS_OFS_STK_IDX);

   // pop reads at the current pointer, push writes one above it
   assign mem_ridx = ptr_q;

   pcrs_stack_mem #(
      .DEPTH (`PCRS_DEPTH),
      .WIDTH (`PCRS_PC_W),
      .AW    (`PCRS_PTR_W)
   ) u_stack_mem (
      .i_clk     (i_clk),
      .i_rst_b   (i_rst_b),
      .i_wr_en   (mem_we),
      .i_wr_idx  (mem_widx),
      .i_wr_lane (mem_lane),
      .i_wr_data (mem_wdata),
      .i_rd_idx  (mem_ridx),
      .o_rd_data (top_of_stack_entry)
   );

   // next-state for counter, latches, pointer, flags and stack writes
   always_comb begin
      pc_d       = pc_q;
      lat_high_d = lat_high_q;
      lat_upr_d  = lat_upr_q;
      ptr_d      = ptr_q;
      ovf_d      = ovf_q;
      udf_d      = udf_q;
      mem_we     = 1'b0;
      mem_widx   = ptr_q;
      mem_lane   = 3'h0;
      mem_wdata  = '0;
      rd_d       = '0;

      // software register writes; flag clears lose to flag sets below
      if (i_bus.wr) begin
         case (i_bus.addr)
            `PCRS_OFS_LAT_HIGH: lat_high_d = i_bus.wdata;
            `PCRS_OFS_LAT_UPR:  lat_upr_d  = i_bus.wdata & `PCRS_UPR_MASK;
            `PCRS_OFS_STK_IDX: begin
               if (!core_busy) begin
                  ptr_d = i_bus.wdata[`PCRS_PTR_W-1:0];
               end
               if (!i_bus.wdata[`PCRS_IDX_OVF_BIT]) begin
                  ovf_d = 1'b0;
               end
               if (!i_bus.wdata[`PCRS_IDX_UDF_BIT]) begin
                  udf_d = 1'b0;
               end
            end
            `PCRS_OFS_TOS_LOW, `PCRS_OFS_TOS_HIGH, `PCRS_OFS_TOS_UPR: begin
               // index zero has nothing behind it, so the write is dropped
               if (!core_busy && (ptr_q != `PCRS_PTR_RST)) begin
                  mem_we    = 1'b1;
                  mem_widx  = ptr_q;
                  mem_wdata = {i_bus.wdata[4:0], i_bus.wdata, i_bus.wdata};
                  mem_lane  = (i_bus.addr == `PCRS_OFS_TOS_LOW)  ? 3'h1 :
                              (i_bus.addr == `PCRS_OFS_TOS_HIGH) ? 3'h2 : 3'h4;
               end
            end
            `PCRS_OFS_PC_LOW: begin
               if (!core_busy) begin
                  // latches move into the counter with the new low byte
                  pc_d = {lat_upr_q[4:0], lat_high_q, i_bus.wdata[7:1], 1'b0};
               end
            end
            default: ;
         endcase
      end

      // software register reads, answered one cycle later
      if (i_bus.rd) begin
         case (i_bus.addr)
            `PCRS_OFS_PC_LOW: begin
               rd_d       = pc_q[7:0];
               lat_high_d = pc_q[15:8];
               lat_upr_d  = {3'h0, pc_q[20:16]};
            end
            `PCRS_OFS_LAT_HIGH: rd_d = lat_high_q;
            `PCRS_OFS_LAT_UPR:  rd_d = lat_upr_q;
            `PCRS_OFS_STK_IDX:  rd_d = {ovf_q, udf_q, full_q, ptr_q};
            `PCRS_OFS_TOS_LOW:  rd_d = top_of_stack_entry[7:0];
            `PCRS_OFS_TOS_HIGH: rd_d = top_of_stack_entry[15:8];
            `PCRS_OFS_TOS_UPR:  rd_d = {3'h0, top_of_stack_entry[20:16]};
            default:            rd_d = '0;
         endcase
      end

      // core operations; none of them touches the latches
      case (i_op.kind)
         pcrs_pkg::PCRS_OP_SEQ: begin
            pc_d = pc_q + `PCRS_PC_STEP;
         end
         pcrs_pkg::PCRS_OP_JUMP: begin
            pc_d = {i_op.target[`PCRS_PC_W-1:1], 1'b0};
         end
         pcrs_pkg::PCRS_OP_CALL, pcrs_pkg::PCRS_OP_INT: begin
            if (do_push) begin
               if (int_taken) begin
                  pc_d = i_op.low_prio ? `PCRS_VEC_LOW : `PCRS_VEC_HIGH;
               end else begin
                  pc_d = {i_op.target[`PCRS_PC_W-1:1], 1'b0};
               end
               if (ptr_q == `PCRS_PTR_MAX) begin
                  // no room left: the pointer holds and nothing is stored
                  ovf_d = 1'b1;
               end else begin
                  ptr_d     = ptr_q + 5'h01;
                  mem_we    = 1'b1;
                  mem_widx  = ptr_q + 5'h01;
                  mem_lane  = 3'h7;
                  mem_wdata = pc_q;
               end
            end
         end
         pcrs_pkg::PCRS_OP_RET: begin
            // software may have stored an odd low byte; alignment still holds
            pc_d = {top_of_stack_entry[`PCRS_PC_W-1:1], 1'b0};
            if (ptr_q == `PCRS_PTR_RST) begin
               udf_d = 1'b1;
            end else begin
               ptr_d = ptr_q - 5'h01;
            end
         end
         default: ;
      endcase

      full_d = (ptr_d == `PCRS_PTR_MAX);
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         pc_q       <= `PCRS_PC_RST;
         lat_high_q <= 8'h00;
         lat_upr_q  <= 8'h00;
         ptr_q      <= `PCRS_PTR_RST;
         ovf_q      <= 1'b0;
         udf_q      <= 1'b0;
         full_q     <= 1'b0;
         rd_q       <= 8'h00;
      end else begin
         pc_q       <= pc_d;
         lat_high_q <= lat_high_d;
         lat_upr_q  <= lat_upr_d;
         ptr_q      <= ptr_d;
         ovf_q      <= ovf_d;
         udf_q      <= udf_d;
         full_q     <= full_d;
         rd_q       <= rd_d;
      end
   end

   assign o_program_counter = pc_q;
   assign o_stack_index     = ptr_q;
   assign o_stack_full      = full_q;
   assign o_stack_overflow  = ovf_q;
   assign o_stack_underflow = udf_q;
   assign o_rd_data         = rd_q;

   // checks
   sequence s_push_ok;
      do_push && (ptr_q != `PCRS_PTR_MAX) && !i_bus.wr;
   endsequence

   sequence s_pop_only;
      do_pop && !i_bus.wr;
   endsequence

   a_pc_aligned: assert property (
      @(posedge i_clk) disable iff (!i_rst_b) pc_q[0] == 1'b0)
      else $error("counter bit 0 is set");

   a_seq_step: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      (i_op.kind == pcrs_pkg::PCRS_OP_SEQ) |=> (pc_q == $past(pc_q) + `PCRS_PC_STEP))
      else $error("sequential step is not two");

   a_jump_target: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      (i_op.kind == pcrs_pkg::PCRS_OP_JUMP)
      |=> (pc_q == {$past(i_op.target[`PCRS_PC_W-1:1]), 1'b0}))
      else $error("jump did not load its target");

   a_push_ptr_inc: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      s_push_ok |=> (ptr_q == $past(ptr_q) + 5'h01) && (top_of_stack_entry == $past(pc_q)))
      else $error("push did not advance pointer and store counter");

   a_pop_ptr_dec: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      s_pop_only and (ptr_q != `PCRS_PTR_RST)
      |=> (ptr_q == $past(ptr_q) - 5'h01) && (pc_q == ($past(top_of_stack_entry) & 21'h1ffffe)))
      else $error("pop did not load counter then decrement");

   a_call_return: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      s_push_ok ##1 s_pop_only |=> (pc_q == $past(pc_q, 2)))
      else $error("return did not restore the pushed counter");

   a_latch_keep: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      (do_push || do_pop) && !i_bus.wr && !i_bus.rd
      |=> $stable(lat_high_q) && $stable(lat_upr_q))
      else $error("call or return changed a latch");

   a_low_write: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      bus_wr_low && !core_busy
      |=> (pc_q[20:8] == {$past(lat_upr_q[4:0]), $past(lat_high_q)}))
      else $error("low byte write did not load latches");

   a_low_read: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      bus_rd_low |=> (lat_high_q == $past(pc_q[15:8]))
                     && (lat_upr_q[4:0] == $past(pc_q[20:16])))
      else $error("low byte read did not copy into latches");

   a_int_vector: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      int_taken |=> (pc_q == ($past(i_op.low_prio) ? `PCRS_VEC_LOW : `PCRS_VEC_HIGH)))
      else $error("interrupt did not load its vector");

   a_overflow_set: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      do_push && (ptr_q == `PCRS_PTR_MAX) |=> ovf_q && (ptr_q == `PCRS_PTR_MAX))
      else $error("overflow not flagged or pointer moved");

   a_underflow_set: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      do_pop && (ptr_q == `PCRS_PTR_RST) |=> udf_q && (ptr_q == `PCRS_PTR_RST))
      else $error("underflow not flagged or pointer moved");

   // flags are sticky: only a write of zero to their bit clears them
   a_ovf_sticky: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      ovf_q && !(idx_wr && !i_bus.wdata[`PCRS_IDX_OVF_BIT]) |=> ovf_q)
      else $error("overflow flag dropped without a clear");

   a_udf_sticky: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      udf_q && !(idx_wr && !i_bus.wdata[`PCRS_IDX_UDF_BIT]) |=> udf_q)
      else $error("underflow flag dropped without a clear");

   a_read_idle: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      !i_bus.rd |=> (rd_q == 8'h00))
      else $error("read data not zero after an idle cycle");

   a_int_ignored: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      (i_op.kind == pcrs_pkg::PCRS_OP_INT) && !int_taken
      |=> $stable(ptr_q) && $stable(pc_q))
      else $error("interrupt without an enable moved the stack");

   a_tos_write: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      i_bus.wr && (i_bus.addr == `PCRS_OFS_TOS_LOW)
      && !core_busy && (ptr_q != `PCRS_PTR_RST)
      |=> (top_of_stack_entry[7:0] == $past(i_bus.wdata)))
      else $error("top entry low byte write did not land");

endmodule

`default_nettype wire

// *** tb/pcrs_core_model.sv ***
// decode and interrupt side model: launches core operations and drives the enables
`timescale 1ns/1ps
`default_nettype none

module pcrs_core_model (
   // operation and interrupt enables toward the block
   output var pcrs_pkg::pcrs_op_t o_op,
   output logic                   o_gie_high,
   output logic                   o_gie_low
);
   initial begin
      o_op       = '0;
      o_gie_high = 1'b0;
      o_gie_low  = 1'b0;
   end

   // caller sits on a rising edge; one op per call, held until the next call
   task automatic issue(input logic [2:0] kind, input logic [20:0] target, input logic lp);
      o_op <= '{kind: pcrs_pkg::pcrs_op_kind_t'(kind), target: target, low_prio: lp};
   endtask

   // enables dropped by the caller around stack edits, so no interrupt push lands mid-edit
   task automatic set_gie(input logic h, input logic l);
      o_gie_high <= h;
      o_gie_low  <= l;
   endtask
endmodule

`default_nettype wire

// *** tb/program_counter_return_stack_tb.sv ***
// self-checking bench for the program counter and return stack block
`timescale 1ns/1ps
`default_nettype none
`include "pcrs_consts.svh"

module program_counter_return_stack_tb;
   logic                i_clk;
   logic                i_rst_b;
   pcrs_pkg::pcrs_bus_t bus;
   wire pcrs_pkg::pcrs_op_t core_op;
   wire logic           gie_h;
   wire logic           gie_l;
   logic [7:0]          rd_data;
   logic [20:0]         pc;
   logic [4:0]          idx;
   logic                full;
   logic                ovf;
   logic                udf;
   logic                want_h;
   logic                want_l;
   logic [31:0]         seed;
   logic [31:0]         r;
   int                  failures;
   int                  checks;
   int                  m_pc, m_ptr, m_hl, m_ul, m_ovf, m_udf, m_rd;
   int                  stk [0:31];

   pcrs_core_model i_core (.o_op(core_op), .o_gie_high(gie_h), .o_gie_low(gie_l));

   pcrs_top i_dut (
      .i_clk(i_clk), .i_rst_b(i_rst_b), .i_op(core_op),
      .i_global_int_enable_high(gie_h), .i_global_int_enable_low(gie_l),
      .i_bus(bus), .o_rd_data(rd_data), .o_program_counter(pc),
      .o_stack_index(idx), .o_stack_full(full),
      .o_stack_overflow(ovf), .o_stack_underflow(udf)
   );

   initial i_clk = 1'b0;
   always #25 i_clk = ~i_clk;

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic chk(input logic [20:0] got, input int exp, input string what);
      checks++;
      if (got !== 21'(exp)) begin
         failures++;
         $display("MISMATCH %0t %s got %0h exp %0h", $time, what, got, exp);
      end
   endtask

   // one cycle: launch a request, check what the previous one left, then model it
   task automatic step(input int k, input int t, input int lp, input int wr, input int rd,
                       input int a, input int wd);
      int busy;
      int v;
      @(posedge i_clk);
      bus <= '{wr: 1'(wr), rd: 1'(rd), addr: 3'(a), wdata: 8'(wd)};
      i_core.issue(3'(k), 21'(t), 1'(lp));
      i_core.set_gie(want_h, want_l);
      #1;
      chk(pc, m_pc, "counter");
      chk(21'(idx), m_ptr, "pointer");
      chk(21'(full), int'(m_ptr == 31), "full");
      chk(21'(ovf), m_ovf, "overflow");
      chk(21'(udf), m_udf, "underflow");
      chk(21'(rd_data), m_rd, "read data");
      busy = int'(k != 0);
      m_rd = 0;
      if (rd != 0) begin
         case (a)
            0: begin
               m_rd = m_pc & 32'hff;
               m_hl = (m_pc >> 8) & 32'hff;
               m_ul = m_pc >> 16;
            end
            1: m_rd = m_hl;
            2: m_rd = m_ul;
            3: m_rd = m_ovf * 128 + m_udf * 64 + int'(m_ptr == 31) * 32 + m_ptr;
            4, 5, 6: m_rd = (m_ptr == 0) ? 0 : (stk[m_ptr] >> (8 * (a - 4))) & 32'hff;
            default: m_rd = 0;
         endcase
      end
      if (wr != 0) begin
         case (a)
            0: if (busy == 0) m_pc = (m_ul << 16) + (m_hl << 8) + (wd & 32'hfe);
            1: m_hl = wd & 32'hff;
            2: m_ul = wd & 32'h1f;
            3: begin
               if (busy == 0) m_ptr = wd & 32'h1f;
               m_ovf = m_ovf & ((wd >> 7) & 1);
               m_udf = m_udf & ((wd >> 6) & 1);
            end
            4, 5, 6: if (busy == 0 && m_ptr != 0) begin
               v = (a == 6) ? (wd & 32'h1f) : (wd & 32'hff);
               stk[m_ptr] = (stk[m_ptr] & ~(32'hff << (8 * (a - 4)))) | (v << (8 * (a - 4)));
            end
            default: ;
         endcase
      end
      if (k == 1) m_pc = (m_pc + 2) & 32'h1ffffe;
      else if (k == 2) m_pc = t & 32'h1ffffe;
      else if (k == 3 || (k == 5 && (want_h || want_l))) begin
         if (m_ptr == 31) m_ovf = 1;
         else begin
            m_ptr++;
            stk[m_ptr] = m_pc;
         end
         m_pc = (k == 3) ? (t & 32'h1ffffe) : ((lp != 0) ? 32'h18 : 32'h8);
      end else if (k == 4) begin
         if (m_ptr == 0) begin
            m_udf = 1;
            m_pc = 0;
         end else begin
            m_pc = stk[m_ptr] & 32'h1ffffe;
            m_ptr--;
         end
      end
   endtask

   task automatic op(input int k, input int t, input int lp);
      step(k, t, lp, 0, 0, 0, 0);
   endtask
   task automatic wr(input int a, input int d);
      step(0, 0, 0, 1, 0, a, d);
   endtask
   task automatic rd(input int a);
      step(0, 0, 0, 0, 1, a, 0);
   endtask

   task automatic close_out();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge i_clk);
      failures++;
      $display("MISMATCH %0t run did not finish", $time);
      close_out();
   end

   initial begin
      i_rst_b = 1'b0;
      bus = '0;
      want_h = 1'b0;
      want_l = 1'b0;
      seed = 32'h0000005b;
      failures = 0;
      checks = 0;
      {m_pc, m_ptr, m_hl, m_ul, m_ovf, m_udf, m_rd} = '0;
      foreach (stk[i]) stk[i] = 0;
      repeat (10) @(posedge i_clk);
      i_rst_b <= 1'b1;
      for (int a = 0; a < 8; a++) rd(a);
      $display("test reset_map done");
      repeat (3) op(1, 0, 0);
      wr(1, 32'h5a);
      wr(2, 32'hff);
      wr(0, 32'h37);
      op(2, 32'h012345, 0);
      rd(0);
      rd(1);
      rd(2);
      $display("test latch_counter done");
      wr(1, 32'h11);
      wr(2, 32'h02);
      for (int i = 0; i < 32; i++) op(3, xs(), 0);
      rd(4);
      rd(5);
      rd(6);
      rd(1);
      rd(2);
      for (int i = 0; i < 32; i++) op(4, 0, 0);
      rd(1);
      rd(3);
      wr(3, 0);
      rd(3);
      $display("test deep_nesting done");
      op(5, 0, 0);
      want_h = 1'b1;
      op(5, 0, 1);
      want_h = 1'b0;
      want_l = 1'b1;
      op(5, 0, 1);
      rd(4);
      want_l = 1'b0;
      op(4, 0, 0);
      op(4, 0, 0);
      $display("test interrupt done");
      wr(3, 32'hc1);
      wr(4, 32'h44);
      wr(5, 32'h33);
      wr(6, 32'hff);
      rd(4);
      rd(6);
      op(4, 0, 0);
      step(1, 0, 0, 1, 0, 3, 32'h05);
      wr(4, 32'h99);
      rd(4);
      $display("test software_stack done");
      for (int i = 0; i < 400; i++) begin
         r = xs();
         want_h = r[20];
         want_l = r[21];
         if (r[9] && (r[7:5] >= 3'h3) && (r[7:5] <= 3'h6)) begin
            // enables off while software touches pointer or top entry
            want_h = 1'b0;
            want_l = 1'b0;
         end
         step(r[3] ? int'(r[2:0]) % 6 : 0, int'(r[28:8]), int'(r[29]),
              int'(r[4] & r[9]), int'(!r[4] & r[9]), int'(r[7:5]), int'(r[31:24]));
      end
      op(0, 0, 0);
      $display("test random_mix done");
      close_out();
   end
endmodule

`default_nettype wire
